// ===== hdl/cei_regs.vh
// Behaviour
// - falling edge sets flag when fall enable
// - disabled edge direction leaves flag unchanged
// - inverting codes 000-011 route pins 0-3
// - inverting code 110 routes reference buffer two
// - inverting code 111 routes analog ground
// - inverting codes 100, 101 leave input open
// - noninverting codes 000, 001 route pins 0, 1
// - noninverting code 101 routes converter output
// - noninverting code 110 routes reference buffer two
// - noninverting code 111 routes analog ground
// - noninverting codes 010-100 leave input open
// - unimplemented upper bits ignore writes, read zero
// - mirror bit k shows instance k result
`ifndef CEI_REGS_VH
`define CEI_REGS_VH

`define CEI_ADDR_W          8
`define CEI_DATA_W          8

// per instance block: instance k at k * stride
`define CEI_BLK_SHIFT       4
`define CEI_OFS_EDGE        4'h0
`define CEI_OFS_NSEL        4'h1
`define CEI_OFS_PSEL        4'h2

// shared registers
`define CEI_OFS_MIRROR      8'h80
`define CEI_OFS_STATUS      8'h81
`define CEI_OFS_CLEAR       8'h82
`define CEI_OFS_ENABLE      8'h83

// field positions
`define CEI_EDGE_FALL_BIT   0
`define CEI_EDGE_RISE_BIT   1
`define CEI_EDGE_W          2
`define CEI_SEL_W           3

// reset values
`define CEI_RST_EDGE        2'h0
`define CEI_RST_SEL         3'h0
`define CEI_RST_MIRROR      8'h00

// inverting selector codes
`define CEI_NSEL_PIN0       3'h0
`define CEI_NSEL_PIN1       3'h1
`define CEI_NSEL_PIN2       3'h2
`define CEI_NSEL_PIN3       3'h3
`define CEI_NSEL_FVR2       3'h6
`define CEI_NSEL_GND        3'h7

// noninverting selector codes
`define CEI_PSEL_PIN0       3'h0
`define CEI_PSEL_PIN1       3'h1
`define CEI_PSEL_DAC        3'h5
`define CEI_PSEL_FVR2       3'h6
`define CEI_PSEL_GND        3'h7

// route enable vector layouts
`define CEI_NROUTE_W        6
`define CEI_NROUTE_FVR2     4
`define CEI_NROUTE_GND      5
`define CEI_PROUTE_W        5
`define CEI_PROUTE_PIN0     0
`define CEI_PROUTE_PIN1     1
`define CEI_PROUTE_DAC      2
`define CEI_PROUTE_FVR2     3
`define CEI_PROUTE_GND      4

`endif

// ===== hdl/cei_sync2.v
`timescale 1ns/100ps
module cei_sync2 #(
    parameter W = 2
) (
    input  wire         clk_i,
    input  wire         rst_b_i,
    input  wire [W-1:0] async_i,
    output wire [W-1:0] sync_o
);
    // first stage is read by the second stage only
    reg [W-1:0] meta_r;
    reg [W-1:0] sync_r;

    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta_r <= {W{1'b0}};
            sync_r <= {W{1'b0}};
        end else begin
            meta_r <= async_i;
            sync_r <= meta_r;
        end
    end

    assign sync_o = sync_r;
endmodule

// ===== hdl/cei_edge_det.v
`timescale 1ns/100ps
module cei_edge_det (
    input  wire clk_i,
    input  wire rst_b_i,
    input  wire level_i,
    input  wire rise_en_i,
    input  wire fall_en_i,
    output wire set_o
);
    reg prev_r;

    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            prev_r <= 1'b0;
        end else begin
            prev_r <= level_i;
        end
    end

    // comparing two consecutive samples gives a pulse exactly one cycle long
    assign set_o = (rise_en_i & ~prev_r & level_i)
                 | (fall_en_i & prev_r & ~level_i);
endmodule

// ===== hdl/cei_top.v
`timescale 1ns/100ps
`include "cei_regs.vh"
module cei_top #(
    parameter NUM_CMP = 2
) (
    input  wire                               clk_i,
    input  wire                               rst_b_i,
    // register port
    input  wire [`CEI_ADDR_W-1:0]             addr_i,
    input  wire [`CEI_DATA_W-1:0]             wdata_i,
    input  wire                               wr_i,
    input  wire                               rd_i,
    output wire [`CEI_DATA_W-1:0]             rdata_o,
    // comparator results, asynchronous to clk_i
    input  wire [NUM_CMP-1:0]                 comparator_result_bit_i,
    // analog route enables, one group per instance
    output wire [NUM_CMP*`CEI_NROUTE_W-1:0]   inverting_input_node_o,
    output wire [NUM_CMP*`CEI_PROUTE_W-1:0]   noninverting_input_node_o,
    // flags, result mirror and interrupt
    output wire [NUM_CMP-1:0]                 comparator_irq_flag_o,
    output wire [NUM_CMP-1:0]                 mirror_result_o,
    output wire                               irq_o
);
    reg  [`CEI_DATA_W-1:0]               rdata_r;
    reg  [`CEI_DATA_W-1:0]               rdata_nxt;
    reg  [NUM_CMP*`CEI_EDGE_W-1:0]       edge_en_r;
    reg  [NUM_CMP*`CEI_SEL_W-1:0]        nsel_r;
    reg  [NUM_CMP*`CEI_SEL_W-1:0]        psel_r;
    reg  [NUM_CMP*`CEI_NROUTE_W-1:0]     nroute_r;
    reg  [NUM_CMP*`CEI_PROUTE_W-1:0]     proute_r;
    reg  [NUM_CMP-1:0]                   flag_r;
    reg  [NUM_CMP-1:0]                   flag_nxt;
    reg  [NUM_CMP-1:0]                   ien_r;
    reg  [NUM_CMP-1:0]                   ien_nxt;
    reg  [NUM_CMP-1:0]                   mirror_r;
    reg                                  irq_r;
    wire [NUM_CMP-1:0]                   res_sync;
    wire [NUM_CMP-1:0]                   flag_set;
    wire [NUM_CMP*`CEI_DATA_W-1:0]       blk_rd;
    wire [NUM_CMP-1:0]                   blk_hit;
    wire [`CEI_DATA_W-1:0]               blk_rd_or;
    wire                                 clr_wr;
    wire                                 ien_wr;

    assign clr_wr = wr_i & (addr_i == `CEI_OFS_CLEAR);
    assign ien_wr = wr_i & (addr_i == `CEI_OFS_ENABLE);

    cei_sync2 #(
        .W (NUM_CMP)
    ) u_sync (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .async_i (comparator_result_bit_i),
        .sync_o  (res_sync)
    );

    genvar k;
    generate
        for (k = 0; k < NUM_CMP; k = k + 1) begin : g_cmp
            localparam integer BLK_I = k;
            localparam [`CEI_ADDR_W-`CEI_BLK_SHIFT-1:0] BLK = BLK_I[`CEI_ADDR_W-`CEI_BLK_SHIFT-1:0];
            wire       hit;
            wire       wr_edge;
            wire       wr_nsel;
            wire       wr_psel;
            wire [2:0] ncode;
            wire [2:0] pcode;
            reg  [`CEI_NROUTE_W-1:0] nroute_nxt;
            reg  [`CEI_PROUTE_W-1:0] proute_nxt;
            reg  [`CEI_DATA_W-1:0]   rd_word;

            assign hit     = (addr_i[`CEI_ADDR_W-1:`CEI_BLK_SHIFT] == BLK);
            assign wr_edge = wr_i & hit & (addr_i[`CEI_BLK_SHIFT-1:0] == `CEI_OFS_EDGE);
            assign wr_nsel = wr_i & hit & (addr_i[`CEI_BLK_SHIFT-1:0] == `CEI_OFS_NSEL);
            assign wr_psel = wr_i & hit & (addr_i[`CEI_BLK_SHIFT-1:0] == `CEI_OFS_PSEL);
            assign ncode   = nsel_r[k*`CEI_SEL_W +: `CEI_SEL_W];
            assign pcode   = psel_r[k*`CEI_SEL_W +: `CEI_SEL_W];

            // only the low field bits are stored; upper write bits are dropped
            always @(posedge clk_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    edge_en_r[k*`CEI_EDGE_W +: `CEI_EDGE_W] <= `CEI_RST_EDGE;
                    nsel_r[k*`CEI_SEL_W +: `CEI_SEL_W]      <= `CEI_RST_SEL;
                    psel_r[k*`CEI_SEL_W +: `CEI_SEL_W]      <= `CEI_RST_SEL;
                end else begin
                    if (wr_edge) begin
                        edge_en_r[k*`CEI_EDGE_W +: `CEI_EDGE_W] <= wdata_i[`CEI_EDGE_W-1:0];
                    end
                    if (wr_nsel) begin
                        nsel_r[k*`CEI_SEL_W +: `CEI_SEL_W] <= wdata_i[`CEI_SEL_W-1:0];
                    end
                    if (wr_psel) begin
                        psel_r[k*`CEI_SEL_W +: `CEI_SEL_W] <= wdata_i[`CEI_SEL_W-1:0];
                    end
                end
            end

            cei_edge_det u_edge (
                .clk_i     (clk_i),
                .rst_b_i   (rst_b_i),
                .level_i   (res_sync[k]),
                .rise_en_i (edge_en_r[k*`CEI_EDGE_W + `CEI_EDGE_RISE_BIT]),
                .fall_en_i (edge_en_r[k*`CEI_EDGE_W + `CEI_EDGE_FALL_BIT]),
                .set_o     (flag_set[k])
            );

            // at most one route closes at a time; open codes close none
            always @* begin
                nroute_nxt = {`CEI_NROUTE_W{1'b0}};
                case (ncode)
                    `CEI_NSEL_PIN0: nroute_nxt[0] = 1'b1;
                    `CEI_NSEL_PIN1: nroute_nxt[1] = 1'b1;
                    `CEI_NSEL_PIN2: nroute_nxt[2] = 1'b1;
                    `CEI_NSEL_PIN3: nroute_nxt[3] = 1'b1;
                    `CEI_NSEL_FVR2: nroute_nxt[`CEI_NROUTE_FVR2] = 1'b1;
                    `CEI_NSEL_GND:  nroute_nxt[`CEI_NROUTE_GND] = 1'b1;
                    default:        nroute_nxt = {`CEI_NROUTE_W{1'b0}};
                endcase
            end

            always @* begin
                proute_nxt = {`CEI_PROUTE_W{1'b0}};
                case (pcode)
                    `CEI_PSEL_PIN0: proute_nxt[`CEI_PROUTE_PIN0] = 1'b1;
                    `CEI_PSEL_PIN1: proute_nxt[`CEI_PROUTE_PIN1] = 1'b1;
                    `CEI_PSEL_DAC:  proute_nxt[`CEI_PROUTE_DAC] = 1'b1;
                    `CEI_PSEL_FVR2: proute_nxt[`CEI_PROUTE_FVR2] = 1'b1;
                    `CEI_PSEL_GND:  proute_nxt[`CEI_PROUTE_GND] = 1'b1;
                    default:        proute_nxt = {`CEI_PROUTE_W{1'b0}};
                endcase
            end

            // registered so switches see no decode glitches
            always @(posedge clk_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    nroute_r[k*`CEI_NROUTE_W +: `CEI_NROUTE_W] <= {`CEI_NROUTE_W{1'b0}};
                    proute_r[k*`CEI_PROUTE_W +: `CEI_PROUTE_W] <= {`CEI_PROUTE_W{1'b0}};
                end else begin
                    nroute_r[k*`CEI_NROUTE_W +: `CEI_NROUTE_W] <= nroute_nxt;
                    proute_r[k*`CEI_PROUTE_W +: `CEI_PROUTE_W] <= proute_nxt;
                end
            end

            always @* begin
                rd_word = {`CEI_DATA_W{1'b0}};
                if (hit) begin
                    case (addr_i[`CEI_BLK_SHIFT-1:0])
                        `CEI_OFS_EDGE: rd_word[`CEI_EDGE_W-1:0] = edge_en_r[k*`CEI_EDGE_W +: `CEI_EDGE_W];
                        `CEI_OFS_NSEL: rd_word[`CEI_SEL_W-1:0]  = ncode;
                        `CEI_OFS_PSEL: rd_word[`CEI_SEL_W-1:0]  = pcode;
                        default:       rd_word = {`CEI_DATA_W{1'b0}};
                    endcase
                end
            end

            assign blk_rd[k*`CEI_DATA_W +: `CEI_DATA_W] = rd_word;
            assign blk_hit[k] = hit;
        end
    endgenerate

    // or-reduce the per instance read words; at most one is non-zero
    genvar b;
    generate
        for (b = 0; b < `CEI_DATA_W; b = b + 1) begin : g_rdor
            wire [NUM_CMP-1:0] col;
            genvar j;
            for (j = 0; j < NUM_CMP; j = j + 1) begin : g_col
                assign col[j] = blk_rd[j*`CEI_DATA_W + b];
            end
            assign blk_rd_or[b] = |col;
        end
    endgenerate

    // a set in the same cycle as its clear wins, so no edge is lost
    always @* begin
        flag_nxt = flag_r & ~({NUM_CMP{clr_wr}} & wdata_i[NUM_CMP-1:0]);
        flag_nxt = flag_nxt | flag_set;
    end

    // irq follows an enable written in the same cycle, not one cycle later
    always @* begin
        ien_nxt = ien_r;
        if (ien_wr) begin
            ien_nxt = wdata_i[NUM_CMP-1:0];
        end
    end

    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            flag_r   <= {NUM_CMP{1'b0}};
            ien_r    <= {NUM_CMP{1'b0}};
            mirror_r <= {NUM_CMP{1'b0}};
            irq_r    <= 1'b0;
        end else begin
            flag_r   <= flag_nxt;
            mirror_r <= res_sync;
            ien_r    <= ien_nxt;
            // flags only reach the interrupt line once software enables them
            irq_r    <= |(flag_nxt & ien_nxt);
        end
    end

    always @* begin
        rdata_nxt = {`CEI_DATA_W{1'b0}};
        if (rd_i) begin
            case (addr_i)
                `CEI_OFS_MIRROR: rdata_nxt[NUM_CMP-1:0] = mirror_r;
                `CEI_OFS_STATUS: rdata_nxt[NUM_CMP-1:0] = flag_r;
                `CEI_OFS_ENABLE: rdata_nxt[NUM_CMP-1:0] = ien_r;
                default: begin
                    if (|blk_hit) begin
                        rdata_nxt = blk_rd_or;
                    end else begin
                        rdata_nxt = {`CEI_DATA_W{1'b0}};
                    end
                end
            endcase
        end
    end

    // read data live only in the cycle after the strobe
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_r <= `CEI_RST_MIRROR;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign rdata_o                   = rdata_r;
    assign inverting_input_node_o    = nroute_r;
    assign noninverting_input_node_o = proute_r;
    assign comparator_irq_flag_o     = flag_r;
    assign mirror_result_o           = mirror_r;
    assign irq_o                     = irq_r;
endmodule

// ===== tb/cei_top_assertions.sv
`timescale 1ns/100ps
`include "cei_regs.vh"
module cei_top_assertions #(
    parameter NUM_CMP = 2
) (
    input wire                              clk_i,
    input wire                              rst_b_i,
    input wire [`CEI_ADDR_W-1:0]            addr_i,
    input wire [`CEI_DATA_W-1:0]            wdata_i,
    input wire                              wr_i,
    input wire                              rd_i,
    input wire [`CEI_DATA_W-1:0]            rdata_o,
    input wire [NUM_CMP-1:0]                comparator_result_bit_i,
    input wire [NUM_CMP*`CEI_NROUTE_W-1:0]  inverting_input_node_o,
    input wire [NUM_CMP*`CEI_PROUTE_W-1:0]  noninverting_input_node_o,
    input wire [NUM_CMP-1:0]                comparator_irq_flag_o,
    input wire [NUM_CMP-1:0]                mirror_result_o,
    input wire                              irq_o
);
    reg [1:0]         edge_r;
    reg [NUM_CMP-1:0] en_r;
    reg [1:0]         age_r;
    function [5:0] nmap(input [2:0] c);
        nmap = (c < 3'h4) ? 6'h01 << c : (c == 3'h6) ? 6'h10 : (c == 3'h7) ? 6'h20 : 6'h00;
    endfunction
    function [4:0] pmap(input [2:0] c);
        pmap = (c < 3'h2) ? 5'h01 << c : (c > 3'h4) ? 5'h04 << (c - 3'h5) : 5'h00;
    endfunction
    // shadow copies of instance 0 edge enables and irq enables
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            edge_r <= 2'h0;
            en_r <= {NUM_CMP{1'b0}};
            age_r <= 2'h0;
        end else begin
            if (wr_i && addr_i == 8'h00) edge_r <= wdata_i[1:0];
            if (wr_i && addr_i == `CEI_OFS_ENABLE) en_r <= wdata_i[NUM_CMP-1:0];
            if (age_r != 2'h3) age_r <= age_r + 2'h1;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    // route flops lag the register by one more edge, so check after three quiet cycles
    sequence s_nwr;
        wr_i && addr_i == 8'h01 ##1 (!(wr_i && addr_i == 8'h01)) [*3];
    endsequence
    sequence s_pwr;
        wr_i && addr_i == 8'h02 ##1 (!(wr_i && addr_i == 8'h02)) [*3];
    endsequence
    a_rise_flag: assert property (
        $rose(mirror_result_o[0]) && $past(edge_r[1]) |-> comparator_irq_flag_o[0])
        else $error("flag not set on rising result");
    a_fall_flag: assert property (
        $fell(mirror_result_o[0]) && $past(edge_r[0]) |-> comparator_irq_flag_o[0])
        else $error("flag not set on falling result");
    a_no_set: assert property (
        $rose(comparator_irq_flag_o[0]) |-> $past(edge_r[1]) && $rose(mirror_result_o[0])
        || $past(edge_r[0]) && $fell(mirror_result_o[0]))
        else $error("flag set without enabled edge");
    a_nsel_route: assert property (
        s_nwr |-> inverting_input_node_o[5:0] == nmap($past(wdata_i[2:0], 3)))
        else $error("inverting route wrong");
    a_psel_route: assert property (
        s_pwr |-> noninverting_input_node_o[4:0] == pmap($past(wdata_i[2:0], 3)))
        else $error("noninverting route wrong");
    a_upper_zero: assert property (
        rd_i && addr_i[3:0] == 4'h0 && addr_i < 8'h20 |=> rdata_o[7:2] == 6'h00)
        else $error("edge register upper bits not zero");
    a_mirror_copy: assert property (
        age_r == 2'h3 |-> mirror_result_o == $past(comparator_result_bit_i, 3))
        else $error("mirror does not follow result");
    a_irq_level: assert property (
        irq_o == |(comparator_irq_flag_o & en_r))
        else $error("irq level wrong");
endmodule

bind cei_top cei_top_assertions #(.NUM_CMP(NUM_CMP)) u_chk (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .comparator_result_bit_i(comparator_result_bit_i), .inverting_input_node_o(inverting_input_node_o),
    .noninverting_input_node_o(noninverting_input_node_o), .comparator_irq_flag_o(comparator_irq_flag_o),
    .mirror_result_o(mirror_result_o), .irq_o(irq_o));

// ===== tb/testbench.sv
`timescale 1ns/100ps
module testbench;
    reg         clk_i, rst_b_i, wr_i, rd_i, rd_d;
    reg  [7:0]  addr_i, wdata_i, d, a;
    reg  [1:0]  cmp;
    wire [7:0]  rdata_o;
    wire [11:0] nroute;
    wire [9:0]  proute;
    wire [1:0]  flag, mirror;
    wire        irq_o;
    integer     err_total, checks, seed, cyc, k, e, c;
    reg  [7:0]  q[$];
    cei_top #(.NUM_CMP(2)) i_cei_top (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .comparator_result_bit_i(cmp),
        .inverting_input_node_o(nroute), .noninverting_input_node_o(proute),
        .comparator_irq_flag_o(flag), .mirror_result_o(mirror), .irq_o(irq_o));
    function [7:0] nexp(input [2:0] c);
        nexp = (c < 3'h4) ? 8'h01 << c : (c == 3'h6) ? 8'h10 : (c == 3'h7) ? 8'h20 : 8'h00;
    endfunction
    function [7:0] pexp(input [2:0] c);
        pexp = (c < 3'h2) ? 8'h01 << c : (c > 3'h4) ? 8'h04 << (c - 3'h5) : 8'h00;
    endfunction
    task chk(input [7:0] seen, input [7:0] exp);
        begin
            checks = checks + 1;
            if (seen !== exp) begin
                err_total = err_total + 1;
                $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task wr(input [7:0] ad, input [7:0] v);
        begin
            @(posedge clk_i);
            addr_i <= ad;
            wdata_i <= v;
            wr_i <= 1'b1;
            @(posedge clk_i);
            wr_i <= 1'b0;
        end
    endtask
    task rd(input [7:0] ad, input [7:0] exp);
        begin
            @(posedge clk_i);
            addr_i <= ad;
            rd_i <= 1'b1;
            q.push_back(exp);
            @(posedge clk_i);
            rd_i <= 1'b0;
        end
    endtask
    task summarize;
        begin
            $display("checks %0d errors %0d", checks, err_total);
            if (err_total == 0 && checks > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    // read data stand only in the cycle after the strobe
    always @(posedge clk_i) begin
        if (rd_d) chk(rdata_o, q.pop_front());
        rd_d <= rd_i;
    end
    always @(posedge clk_i) begin
        cyc = cyc + 1;
        if (cyc > 20000) begin
            err_total = err_total + 1;
            summarize;
        end
    end
    initial begin
        seed = 82817;
        err_total = 0;
        checks = 0;
        cyc = 0;
        rst_b_i = 1'b0;
        {wr_i, rd_i, rd_d, addr_i, wdata_i, cmp} = 0;
        repeat (6) @(posedge clk_i);
        rst_b_i <= 1'b1;
        for (k = 0; k < 6; k = k + 1) begin
            a = 8'(16 * (k / 3) + k % 3);
            rd(a, 8'h00);
            d = $random(seed);
            wr(a, d);
            rd(a, d & ((k % 3 == 0) ? 8'h03 : 8'h07));
        end
        wr(8'h40, d);
        rd(8'h40, 8'h00);
        rd(8'h82, 8'h00);
        for (k = 0; k < 2; k = k + 1)
            for (c = 0; c < 8; c = c + 1) begin
                d = $random(seed);
                wr(8'(16 * k + 1), {d[7:3], c[2:0]});
                wr(8'(16 * k + 2), {d[7:3], ~c[2:0]});
                repeat (3) @(posedge clk_i);
                chk({2'h0, nroute[6*k +: 6]}, nexp(c[2:0]));
                chk({3'h0, proute[5*k +: 5]}, pexp(~c[2:0]));
            end
        // masked case e=2 shows a flag with irq held low
        for (k = 0; k < 2; k = k + 1)
            for (e = 0; e < 4; e = e + 1) begin
                wr(8'(16 * k), 8'(e));
                wr(8'h83, 8'(e % 2 << k));
                @(posedge clk_i);
                cmp[k] <= 1'b1;
                repeat (5) @(posedge clk_i);
                chk({7'h0, irq_o}, 8'(e / 2 * (e % 2)));
                chk({6'h0, flag}, 8'(e / 2 << k));
                chk({6'h0, mirror}, 8'(1 << k));
                wr(8'h81, 8'hFF);
                rd(8'h81, 8'(e / 2 << k));
                rd(8'h80, 8'(1 << k));
                wr(8'h82, 8'h03);
                rd(8'h81, 8'h00);
                chk({7'h0, irq_o}, 8'h00);
                cmp[k] <= 1'b0;
                repeat (5) @(posedge clk_i);
                chk({7'h0, irq_o}, 8'(e % 2));
                chk({6'h0, flag}, 8'(e % 2 << k));
                chk({6'h0, mirror}, 8'h00);
                rd(8'h81, 8'(e % 2 << k));
                rd(8'h80, 8'h00);
                wr(8'h82, 8'h03);
            end
        repeat (3) @(posedge clk_i);
        summarize;
    end
endmodule
